// >>> pkg/plsi_pkg.sv
// Package: constants, register map and carrier types of the port low-speed I/O block
package plsi_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int NPORTS  = 4;
    localparam int NIN     = 3;
    localparam int NBITS   = NPORTS * NIN;
    localparam int NOUTB   = 2 * NPORTS;
    localparam int APB_AW  = 8;
    localparam int SYNC_W  = NBITS + 1;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [APB_AW-1:0] OFF_OUT_EN   = 8'h00;
    localparam logic [APB_AW-1:0] OFF_OUT_VAL  = 8'h04;
    localparam logic [APB_AW-1:0] OFF_OUT_PORT = 8'h08;
    localparam logic [APB_AW-1:0] OFF_OUT_ALL  = 8'h0C;
    localparam logic [APB_AW-1:0] OFF_IN_STAT  = 8'h10;
    localparam logic [APB_AW-1:0] OFF_EDGE_CFG = 8'h14;
    localparam logic [APB_AW-1:0] OFF_FLAG     = 8'h18;
    localparam logic [APB_AW-1:0] OFF_MASK     = 8'h1C;
    localparam logic [APB_AW-1:0] OFF_PORT_AGG = 8'h20;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int OP_SEL_LSB   = 0;
    localparam int OP_EN_LSB    = 2;
    localparam int OP_VAL_LSB   = 4;
    localparam int ALL_EN_LSB   = 0;
    localparam int ALL_VAL_LSB  = 2;
    localparam int STAT_WIRE_BIT = 16;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [NOUTB-1:0] RST_OUT_EN  = 8'h00;
    localparam logic [NOUTB-1:0] RST_OUT_VAL = 8'h55;
    localparam logic [23:0]      RST_EDGE    = 24'h00_0000;
    localparam logic [31:0]      RST_RDATA   = 32'h0000_0000;
    localparam logic [2:0]       ARM_CYCLES  = 3'h5;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 10;
    localparam int INT_MAX_US   = 50;
    localparam int INT_MAX_CYC  = INT_MAX_US * CLK_FREQ_MHZ;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NBITS-1:0] fall;
        logic [NBITS-1:0] rise;
    } plsi_edge_t;

    typedef struct packed {
        logic [NPORTS-1:0] a;
        logic [NPORTS-1:0] b;
    } plsi_outs_t;

endpackage : plsi_pkg

// >>> rtl/plsi_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps

module plsi_sync #(
    parameter int W = 13
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] level
);

    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] next_level;

    // ------------------------------------------------------------------
    // Level follows only when stages two and three agree
    // ------------------------------------------------------------------
    genvar gb;
    generate
        for (gb = 0; gb < W; gb++) begin : g_bit
            always_comb begin
                next_level[gb] = (ff2[gb] == ff3[gb]) ? ff3[gb] : level[gb];
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ff1   <= '0;
            ff2   <= '0;
            ff3   <= '0;
            level <= '0;
        end else begin
            ff1   <= din;
            ff2   <= ff1;
            ff3   <= ff2;
            level <= next_level;
        end
    end

endmodule : plsi_sync

// >>> rtl/plsi_top.sv
// Port low-speed outputs, monitored inputs and wired-or host interrupt behind APB
//
// Contract
// [R01] Two outputs per port; single, all, broadcast update
// [R02] Enable register; all outputs disabled after reset
// [R03] Value register; resets A high, B low
// [R04] Host sets values before enabling outputs
// [R05] Three monitored inputs sampled per port
// [R06] Live input levels readable by host
// [R07] Enabled edges raise interrupt: rise, fall, both
// [R08] One flag register records input and edge
// [R09] Interrupt active low; events user selectable
// [R10] Interrupt only pulls low; shared wired-or
// [R11] Interrupt within 50 us of input change
// [R12] Host checks aggregated port flags, then status
// [R13] Inputs synchronised; each edge one-cycle pulse
// [R14] Flags sticky until host clears them
`timescale 1ns/1ps

module plsi_top (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [plsi_pkg::APB_AW-1:0]  paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         bcast_sel,
    input  wire logic [plsi_pkg::NBITS-1:0]   mod_in,
    output plsi_pkg::plsi_outs_t              out_val,
    output plsi_pkg::plsi_outs_t              out_oe,
    input  wire logic                         host_int_n_i,
    output logic                              host_int_n_o,
    output logic                              host_int_n_oe
);

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic wr_acc;
    logic setup;
    logic mapped;

    assign wr_acc = psel & penable & pwrite;
    assign setup  = psel & ~penable;
    // Read data is registered in setup, so every access completes at once
    assign pready = 1'b1;

    always_comb begin
        unique case (paddr)
            plsi_pkg::OFF_OUT_EN,
            plsi_pkg::OFF_OUT_VAL,
            plsi_pkg::OFF_OUT_PORT,
            plsi_pkg::OFF_OUT_ALL,
            plsi_pkg::OFF_IN_STAT,
            plsi_pkg::OFF_EDGE_CFG,
            plsi_pkg::OFF_FLAG,
            plsi_pkg::OFF_MASK,
            plsi_pkg::OFF_PORT_AGG: mapped = 1'b1;
            default:                mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Output control: index 2p is output A of port p, 2p+1 is B
    // ------------------------------------------------------------------
    logic [plsi_pkg::NOUTB-1:0] out_en;
    logic [plsi_pkg::NOUTB-1:0] out_lvl;
    logic [plsi_pkg::NOUTB-1:0] next_out_en;
    logic [plsi_pkg::NOUTB-1:0] next_out_lvl;

    always_comb begin
        next_out_en  = out_en;
        next_out_lvl = out_lvl;
        if (wr_acc) begin
            unique case (paddr)
                plsi_pkg::OFF_OUT_EN: begin
                    next_out_en = pwdata[plsi_pkg::NOUTB-1:0];  // R02
                end
                plsi_pkg::OFF_OUT_VAL: begin
                    next_out_lvl = pwdata[plsi_pkg::NOUTB-1:0];  // R03
                end
                plsi_pkg::OFF_OUT_PORT: begin
                    // A broadcast select turns a single-port write into a
                    // write to every port
                    for (int p = 0; p < plsi_pkg::NPORTS; p++) begin
                        if (bcast_sel || (pwdata[plsi_pkg::OP_SEL_LSB +: 2] == 2'(p))) begin
                            next_out_en[2*p +: 2]  = pwdata[plsi_pkg::OP_EN_LSB +: 2];  // R01
                            next_out_lvl[2*p +: 2] = pwdata[plsi_pkg::OP_VAL_LSB +: 2];  // R01
                        end
                    end
                end
                plsi_pkg::OFF_OUT_ALL: begin
                    for (int p = 0; p < plsi_pkg::NPORTS; p++) begin
                        next_out_en[2*p +: 2]  = pwdata[plsi_pkg::ALL_EN_LSB +: 2];  // R01
                        next_out_lvl[2*p +: 2] = pwdata[plsi_pkg::ALL_VAL_LSB +: 2];  // R01
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_en  <= plsi_pkg::RST_OUT_EN;  // R02
            out_lvl <= plsi_pkg::RST_OUT_VAL;  // R03
        end else begin
            out_en  <= next_out_en;
            out_lvl <= next_out_lvl;
        end
    end

    genvar gp;
    generate
        for (gp = 0; gp < plsi_pkg::NPORTS; gp++) begin : g_out
            assign out_val.a[gp] = out_lvl[2*gp];
            assign out_val.b[gp] = out_lvl[2*gp+1];
            assign out_oe.a[gp]  = out_en[2*gp];
            assign out_oe.b[gp]  = out_en[2*gp+1];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Input synchronisation and edge events
    // ------------------------------------------------------------------
    logic [plsi_pkg::SYNC_W-1:0] lvl;
    logic [plsi_pkg::NBITS-1:0]  lvl_prev;
    logic [2:0]                  arm_cnt;
    logic [2:0]                  next_arm_cnt;
    logic                        armed;
    plsi_pkg::plsi_edge_t        evt;

    plsi_sync #(
        .W (plsi_pkg::SYNC_W)
    ) u_sync (  // R05
        .pclk    (pclk),
        .presetn (presetn),
        .din     ({host_int_n_i, mod_in}),
        .level   (lvl)
    );

    // Suppress edges while the synchroniser fills after reset
    assign armed = (arm_cnt == plsi_pkg::ARM_CYCLES);

    always_comb begin
        next_arm_cnt = armed ? arm_cnt : arm_cnt + 3'h1;
        evt.rise     = armed ? (lvl[plsi_pkg::NBITS-1:0] & ~lvl_prev) : '0;  // R13
        evt.fall     = armed ? (~lvl[plsi_pkg::NBITS-1:0] & lvl_prev) : '0;  // R13
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arm_cnt  <= 3'h0;
            lvl_prev <= '0;
        end else begin
            arm_cnt  <= next_arm_cnt;
            lvl_prev <= lvl[plsi_pkg::NBITS-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Edge selection, sticky flags, mask and interrupt pin
    // ------------------------------------------------------------------
    plsi_pkg::plsi_edge_t edge_cfg;
    plsi_pkg::plsi_edge_t flag;
    plsi_pkg::plsi_edge_t mask;
    plsi_pkg::plsi_edge_t next_edge_cfg;
    plsi_pkg::plsi_edge_t next_flag;
    plsi_pkg::plsi_edge_t next_mask;
    plsi_pkg::plsi_edge_t clr;
    plsi_pkg::plsi_edge_t hit;
    plsi_pkg::plsi_edge_t pend;
    logic                 int_act;
    logic                 next_int_act;
    logic [plsi_pkg::NPORTS-1:0] port_agg;

    always_comb begin
        next_edge_cfg = edge_cfg;
        next_mask     = mask;
        clr           = '0;
        if (wr_acc && (paddr == plsi_pkg::OFF_EDGE_CFG)) begin
            next_edge_cfg = plsi_pkg::plsi_edge_t'(pwdata[23:0]);  // R09
        end
        if (wr_acc && (paddr == plsi_pkg::OFF_MASK)) begin
            next_mask = plsi_pkg::plsi_edge_t'(pwdata[23:0]);
        end
        if (wr_acc && (paddr == plsi_pkg::OFF_FLAG)) begin
            clr = plsi_pkg::plsi_edge_t'(pwdata[23:0]);  // R14
        end
        hit          = evt & edge_cfg;  // R07
        // A new edge in the clearing cycle survives the clear
        next_flag    = (flag & ~clr) | hit;  // R08 R14
        pend         = next_flag & mask;
        next_int_act = |pend;  // R07 R11
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_cfg <= plsi_pkg::RST_EDGE;
            flag     <= plsi_pkg::RST_EDGE;
            mask     <= plsi_pkg::RST_EDGE;
            int_act  <= 1'b0;
        end else begin
            edge_cfg <= next_edge_cfg;
            flag     <= next_flag;
            mask     <= next_mask;
            int_act  <= next_int_act;
        end
    end

    // Open drain: the pin is only ever pulled low, never driven high
    assign host_int_n_o  = 1'b0;  // R10
    assign host_int_n_oe = int_act;  // R09 R10

    generate
        for (gp = 0; gp < plsi_pkg::NPORTS; gp++) begin : g_agg
            assign port_agg[gp] = |((flag.rise[3*gp +: 3] & mask.rise[3*gp +: 3])
                                  | (flag.fall[3*gp +: 3] & mask.fall[3*gp +: 3]));  // R12
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read data, captured in the setup cycle
    // ------------------------------------------------------------------
    logic [31:0] next_prdata;
    logic        next_pslverr;

    always_comb begin
        next_prdata  = prdata;
        next_pslverr = pslverr;
        if (setup) begin
            next_pslverr = ~mapped;
            next_prdata  = plsi_pkg::RST_RDATA;
            if (!pwrite) begin
                unique case (paddr)
                    plsi_pkg::OFF_OUT_EN:   next_prdata = {24'h00_0000, out_en};
                    plsi_pkg::OFF_OUT_VAL:  next_prdata = {24'h00_0000, out_lvl};
                    plsi_pkg::OFF_IN_STAT:  next_prdata = {15'h0000, lvl[plsi_pkg::NBITS],
                                                           4'h0, lvl[plsi_pkg::NBITS-1:0]};  // R06
                    plsi_pkg::OFF_EDGE_CFG: next_prdata = {8'h00, edge_cfg};
                    plsi_pkg::OFF_FLAG:     next_prdata = {8'h00, flag};  // R08
                    plsi_pkg::OFF_MASK:     next_prdata = {8'h00, mask};
                    plsi_pkg::OFF_PORT_AGG: next_prdata = {28'h000_0000, port_agg};  // R12
                    default:                next_prdata = plsi_pkg::RST_RDATA;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= plsi_pkg::RST_RDATA;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    localparam int INT_BOUND = plsi_pkg::INT_MAX_CYC;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_port_wr;
        wr_acc && (paddr == plsi_pkg::OFF_OUT_PORT) && !bcast_sel;
    endsequence

    sequence s_in0_steady;
        $stable(mod_in[0]) [*6];
    endsequence

    sequence s_rise0_sel;
        evt.rise[0] && edge_cfg.rise[0];
    endsequence

    // Measured from the pin, so synchroniser and flag stages both count
    sequence s_rise1_armed;
        $rose(mod_in[1]) && armed && edge_cfg.rise[1] && mask.rise[1];
    endsequence

    AST_EN_HOLD: assert property (!wr_acc |=> $stable(out_oe))  // R02
        else $error("output enables changed without a write");

    AST_VAL_HOLD: assert property (!wr_acc |=> $stable(out_val))  // R03
        else $error("output values changed without a write");

    AST_PORT_WR: assert property (s_port_wr |=>
        out_oe.a[$past(pwdata[1:0])] == $past(pwdata[2]))  // R01
        else $error("single-port write did not set output A enable");

    AST_ALL_WR: assert property (wr_acc && (paddr == plsi_pkg::OFF_OUT_ALL) |=>
        out_val.b == {plsi_pkg::NPORTS{$past(pwdata[3])}})  // R01
        else $error("all-port write did not set every output B value");

    AST_SYNC_LAT: assert property (s_in0_steady |-> lvl[0] == mod_in[0])  // R13
        else $error("synchronised level does not follow a steady input");

    AST_RISE_PULSE: assert property (evt.rise[0] |=> !evt.rise[0])  // R13
        else $error("rise event lasted more than one cycle");

    AST_FLAG_SET: assert property (s_rise0_sel |=> flag.rise[0])  // R07
        else $error("selected rising edge did not set its flag");

    AST_FALL_FLAG: assert property (evt.fall[1] && edge_cfg.fall[1] |=> flag.fall[1])  // R08
        else $error("selected falling edge did not set its flag");

    AST_FLAG_STICKY: assert property (flag.rise[0] &&
        !(wr_acc && (paddr == plsi_pkg::OFF_FLAG) && pwdata[0]) |=> flag.rise[0])  // R14
        else $error("flag dropped without a clearing write");

    AST_INT_LAT: assert property (s_rise1_armed |-> ##[1:INT_BOUND] host_int_n_oe)  // R11
        else $error("interrupt not asserted within the maximum delay");

    AST_INT_IDLE: assert property (!(|(flag & mask)) && !(|evt) |=> !host_int_n_oe)  // R09
        else $error("interrupt pulled low with no pending unmasked flag");

    AST_STAT_RD: assert property (setup && !pwrite && (paddr == plsi_pkg::OFF_IN_STAT) |=>
        prdata[11:0] == $past(lvl[11:0]))  // R06
        else $error("input status read returned wrong levels");

endmodule : plsi_top

// >>> dv/plsi_line_model.sv
// Far-side model: shared wired-or interrupt line with pull-up and one other device
`timescale 1ns/1ps

module plsi_line_model (
    input  wire logic int_n_o,
    input  wire logic int_n_oe,
    input  wire logic other_low,
    output logic      line_n
);
    // Pull-up keeps the line high unless some device sinks it
    assign line_n = ((int_n_oe && !int_n_o) || other_low) ? 1'b0 : 1'b1;
endmodule : plsi_line_model

// >>> dv/testbench.sv
// Self-checking testbench of the port low-speed I/O block
`timescale 1ns/1ps

module testbench;
    logic                 pclk = 1'b0;
    logic                 presetn = 1'b0;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic [7:0]           paddr = 8'h00;
    logic [31:0]          pwdata = 32'h0000_0000;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 bcast_sel = 1'b0;
    logic [11:0]          mod_in = 12'h000;
    plsi_pkg::plsi_outs_t out_val;
    plsi_pkg::plsi_outs_t out_oe;
    logic                 line_n;
    logic                 int_n_o;
    logic                 int_n_oe;
    logic                 other_low = 1'b0;
    logic [7:0]           en_m;
    logic [7:0]           val_m;
    logic [31:0]          q;
    logic                 e;
    int                   errors = 0;
    int                   checks_done = 0;

    always #50 pclk = ~pclk;

    plsi_top plsi_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bcast_sel(bcast_sel), .mod_in(mod_in), .out_val(out_val),
        .out_oe(out_oe), .host_int_n_i(line_n), .host_int_n_o(int_n_o),
        .host_int_n_oe(int_n_oe));

    plsi_line_model plsi_line_model_i (.int_n_o(int_n_o), .int_n_oe(int_n_oe),
        .other_low(other_low), .line_n(line_n));

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, x, g);
        end
    endtask : chk

    // One APB transfer; an idle cycle before setup keeps drivers single-assigned
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rq, output logic re);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait-state count assumed; only the watchdog ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(nm, x, q);
    endtask : rdc

    function automatic logic [7:0] outs(input logic [7:0] r);
        logic [3:0] a;
        logic [3:0] b;
        for (int p = 0; p < 4; p++) begin
            a[p] = r[2*p];
            b[p] = r[2*p+1];
        end
        return {a, b};
    endfunction : outs

    task automatic chk_outs;
        repeat (2) @(posedge pclk);
        #1;
        chk("out_val", {24'h0, outs(val_m)}, {24'h0, out_val});
        chk("out_oe", {24'h0, outs(en_m)}, {24'h0, out_oe});
    endtask : chk_outs

    task automatic upd(input int p, input logic [1:0] en, input logic [1:0] v);
        en_m[2*p+:2] = en;
        val_m[2*p+:2] = v;
    endtask : upd

    task automatic edge_case(input int k, input logic up, input logic [23:0] cfg,
                             input logic msk);
        logic [23:0] f;
        logic        x;
        int          n;
        f = (up ? (24'h00_0001 << k) : (24'h00_0001 << (k + 12))) & cfg;
        x = (f != 24'h00_0000) && msk;
        n = 0;
        apb(1'b1, plsi_pkg::OFF_EDGE_CFG, {8'h00, cfg}, q, e);
        apb(1'b1, plsi_pkg::OFF_MASK, msk ? 32'h00ff_ffff : 32'h0000_0000, q, e);
        mod_in[k] <= up;
        while (x && int_n_oe !== 1'b1 && n < 600) begin
            @(posedge pclk);
            n++;
        end
        chk("int_delay_ok", 32'h1, {31'h0, n <= plsi_pkg::INT_MAX_CYC});
        // Flag must still hold the line well after the edge
        repeat (30) @(posedge pclk);
        #1;
        chk("int_oe", {31'h0, x}, {31'h0, int_n_oe});
        chk("line_n", {31'h0, !x}, {31'h0, line_n});
        chk("int_n_o", 32'h0, {31'h0, int_n_o});
        rdc("port_agg", plsi_pkg::OFF_PORT_AGG, x ? (32'h1 << (k / 3)) : 32'h0);
        rdc("flag", plsi_pkg::OFF_FLAG, {8'h00, f});
        apb(1'b1, plsi_pkg::OFF_FLAG, {8'h00, f}, q, e);
        rdc("flag_clr", plsi_pkg::OFF_FLAG, 32'h0000_0000);
        #1;
        chk("int_oe_clr", 32'h0, {31'h0, int_n_oe});
    endtask : edge_case

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        logic [23:0] cfg;
        int          k;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        en_m = 8'h00;
        val_m = 8'h55;
        repeat (2) @(posedge pclk);
        #1;
        chk("rst_val", 32'h0000_00f0, {24'h0, out_val});
        chk("rst_oe", 32'h0, {24'h0, out_oe});
        chk("rst_int", 32'h0, {31'h0, int_n_oe});
        rdc("rst_en", plsi_pkg::OFF_OUT_EN, 32'h0000_0000);
        rdc("rst_valr", plsi_pkg::OFF_OUT_VAL, 32'h0000_0055);
        rdc("rst_cfg", plsi_pkg::OFF_EDGE_CFG, 32'h0000_0000);
        rdc("rst_flag", plsi_pkg::OFF_FLAG, 32'h0000_0000);
        $display("test reset done");

        // Values first, enables second, so no stray level reaches a module
        apb(1'b1, plsi_pkg::OFF_OUT_VAL, 32'h0000_0096, q, e);
        apb(1'b1, plsi_pkg::OFF_OUT_EN, 32'h0000_003c, q, e);
        val_m = 8'h96;
        en_m = 8'h3c;
        chk_outs();
        apb(1'b1, plsi_pkg::OFF_OUT_PORT, 32'h0000_0026, q, e);
        upd(2, 2'b01, 2'b10);
        chk_outs();
        @(posedge pclk);
        bcast_sel <= 1'b1;
        apb(1'b1, plsi_pkg::OFF_OUT_PORT, 32'h0000_001d, q, e);
        bcast_sel <= 1'b0;
        for (int p = 0; p < 4; p++) upd(p, 2'b11, 2'b01);
        chk_outs();
        apb(1'b1, plsi_pkg::OFF_OUT_ALL, 32'h0000_000a, q, e);
        for (int p = 0; p < 4; p++) upd(p, 2'b10, 2'b10);
        chk_outs();
        $display("test outputs done");

        // Rising, falling and both-edge selection, on inputs of three ports
        for (int m = 0; m < 3; m++) begin
            k = 4 * m + 1;
            cfg = ((m != 1) ? (24'h00_0001 << k) : 24'h00_0000)
                | ((m != 0) ? (24'h00_0001 << (k + 12)) : 24'h00_0000);
            edge_case(k, 1'b1, cfg, 1'b1);
            edge_case(k, 1'b0, cfg, 1'b1);
        end
        edge_case(0, 1'b1, 24'h00_0001, 1'b0);
        $display("test interrupts done");

        @(posedge pclk);
        mod_in <= 12'ha5c;
        repeat (10) @(posedge pclk);
        rdc("in_stat", plsi_pkg::OFF_IN_STAT, 32'h0001_0a5c);
        apb(1'b1, plsi_pkg::OFF_IN_STAT, 32'hffff_ffff, q, e);
        chk("ro_err", 32'h0, {31'h0, e});
        other_low <= 1'b1;
        repeat (10) @(posedge pclk);
        rdc("in_stat_w", plsi_pkg::OFF_IN_STAT, 32'h0000_0a5c);
        apb(1'b0, 8'h40, 32'h0000_0000, q, e);
        chk("unm_err", 32'h1, {31'h0, e});
        chk("unm_data", 32'h0, q);
        $display("test status done");
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        wrap_up();
    end
endmodule : testbench
